/* File: dv/aice_enc_model.sv */
// Encoder model: quadrature A/B or separate up/down pulse lines.
// Assumes the bench raises step_in for one clock per encoder edge.
`timescale 1ns/1ps
module aice_enc_model (
  // Clock
  input wire logic ref_clk_in,
  // Control
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic updown_in,
  // Encoder lines
  output logic a_out,
  output logic b_out
);
  logic [1:0] ph_ff = 2'h0;
  always_ff @(posedge ref_clk_in) begin
    if (step_in) begin
      ph_ff <= dir_in ? ph_ff + 2'h1 : ph_ff - 2'h1;
    end
  end
  // Gray code, or one pulse per two steps on the up or down line
  assign a_out = updown_in ? (dir_in & ph_ff[0]) : ph_ff[1];
  assign b_out = updown_in ? (~dir_in & ph_ff[0]) : (ph_ff[1] ^ ph_ff[0]);
endmodule : aice_enc_model

/* File: dv/test_axis_input_conditioning_events.sv */
// Bench for the axis input conditioning and event block.
// Assumes aice_top and the encoder model are compiled first.
`timescale 1ns/1ps
module test_axis_input_conditioning_events;
  logic ref_clk_in, rst_b_in = 1'h0, emergency_stop_in = 1'h0, err_clr_in = 1'h0;
  logic filter_en_limits_group_in = 1'h0, filter_en_index_group_in = 1'h0;
  logic filter_en_servo_group_in = 1'h0, filter_en_manual_pulse_group_in = 1'h0;
  logic filter_en_aux_input_group_in = 1'h0, mpg_drv = 1'h0, step = 1'h0, step_dir = 1'h0;
  logic [2:0] filt_code_in = '0;
  logic [1:0] hard_limit_pos_in = '0, hard_limit_neg_in = '0, home_sensor_in = '0;
  logic [1:0] near_home_sensor_in = '0, index_stop_in = '0, servo_alarm_in = '0;
  logic [1:0] in_position_in = '0, aux_input_three_in = '0, pol_limit_in = '0;
  logic [1:0] pol_home_in = '0, pol_near_home_in = '0, pol_index_in = '0, alarm_en_in = '0;
  logic [1:0] pol_alarm_in = '0, inpos_en_in = '0, pol_inpos_in = '0, enc_updown_in = '0;
  logic [1:0] pls_req_in = '0, dir_req_in = '0, const_speed_in = '0, driving_in = '0;
  logic [3:0] enc_div_in = '0;
  logic [5:0] pls_mode_in = '0;
  logic [63:0] pos_cnt_in = '0, comp_neg_in = '0, comp_pos_in = '0;
  logic [13:0] ev_en_in = '0, ev_clr_in = '0, ev_flags_out;
  logic [1:0] manual_pulse_pos_in, manual_pulse_neg_in, cw_out, ccw_out, enc_up_out;
  logic [1:0] enc_dn_out, limit_pos_act_out, limit_neg_act_out, home_act_out, aux3_out;
  logic [1:0] near_home_act_out, index_act_out, alarm_act_out, inpos_act_out, mpg_pos_out;
  logic [1:0] mpg_neg_out, s00, s01, s10, s11;
  logic irq_out, emg_error_out, enc_a, enc_b;
  logic [13:0] exp_q[$];
  logic [15:0] rnd = 16'h1EB8;
  int n_errors = 0, check_count = 0, n_up = 0, n_dn = 0;
  // Axis 0 walk: position, constant speed, driving, flags
  int ev_tab[7][4] = '{'{5, 0, 0, 7'h01},
    '{4, 0, 0, 7'h03},
    '{12, 0, 0, 7'h07},
    '{3, 0, 0, 7'h0F},
    '{3, 1, 1, 7'h2F},
    '{3, 0, 1, 7'h3F},
    '{3, 0, 0, 7'h7F}};
  // Axis 1 runs of 16 steps: direction, up/down mode, division, count
  int enc_tab[6][4] = '{'{1, 0, 0, 16}, '{1, 0, 1, 8}, '{1, 0, 2, 4},
    '{0, 0, 0, 16}, '{1, 1, 0, 8}, '{0, 1, 0, 8}};

  assign manual_pulse_pos_in = {enc_a, mpg_drv};
  assign manual_pulse_neg_in = {enc_b, 1'h0};

  aice_top #(.BASE_CYC(16)) DUT (.*);
  aice_enc_model u_enc (.ref_clk_in, .step_in(step), .dir_in(step_dir),
    .updown_in(enc_updown_in[1]), .a_out(enc_a), .b_out(enc_b));

  // ****
  // Helpers
  // ****
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : cyc

  task automatic check(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    check(exp_q.size(), 0);
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic set_grp(logic [4:0] v);
    {filter_en_aux_input_group_in, filter_en_manual_pulse_group_in, filter_en_servo_group_in,
      filter_en_index_group_in, filter_en_limits_group_in} = v;
  endtask : set_grp

  task automatic grp_drive(int g, logic v);
    case (g)
      0: home_sensor_in[0] = v;
      1: index_stop_in[0] = v;
      2: servo_alarm_in[0] = v;
      3: mpg_drv = v;
      default: aux_input_three_in[0] = v;
    endcase
  endtask : grp_drive

  function automatic logic grp_seen(int g);
    case (g)
      0: return home_act_out[0];
      1: return index_act_out[0];
      2: return alarm_act_out[0];
      3: return mpg_pos_out[0];
      default: return aux3_out[0];
    endcase
  endfunction : grp_seen

  task automatic smp(logic p, logic d, output logic [1:0] s);
    pls_req_in[0] = p;
    dir_req_in[0] = d;
    cyc(4);
    s = {cw_out[0], ccw_out[0]};
  endtask : smp

  // ****
  // Clock, watchdog, monitors
  // ****
  initial begin
    ref_clk_in = 1'h0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_errors++;
    conclude();
  end

  always @(ev_flags_out) begin
    if (rst_b_in === 1'h1) begin
      check(ev_flags_out, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    end
  end

  always @(posedge ref_clk_in) begin
    n_up += int'(enc_up_out[1]);
    n_dn += int'(enc_dn_out[1]);
  end

  // ****
  // Scenarios
  // ****
  initial begin
    cyc(16);
    rst_b_in = 1'h1;
    cyc(2);
    check({ev_flags_out, irq_out, emg_error_out}, 0);
    repeat (20) begin
      rnd = lfsr(rnd);
      {hard_limit_pos_in, hard_limit_neg_in, pol_limit_in, home_sensor_in, pol_home_in,
        near_home_sensor_in, pol_near_home_in, index_stop_in} = rnd;
      rnd = lfsr(rnd);
      {pol_index_in, servo_alarm_in, alarm_en_in, pol_alarm_in, in_position_in, inpos_en_in,
        pol_inpos_in, aux_input_three_in} = rnd;
      cyc(4);
      check(limit_pos_act_out, (hard_limit_pos_in ~^ pol_limit_in) & 2'h3);
      check(limit_neg_act_out, (hard_limit_neg_in ~^ pol_limit_in) & 2'h3);
      check(home_act_out, (home_sensor_in ~^ pol_home_in) & 2'h3);
      check(near_home_act_out, (near_home_sensor_in ~^ pol_near_home_in) & 2'h3);
      check(index_act_out, (index_stop_in ~^ pol_index_in) & 2'h3);
      check(alarm_act_out, alarm_en_in & (servo_alarm_in ~^ pol_alarm_in));
      check(inpos_act_out, inpos_en_in & (in_position_in ~^ pol_inpos_in));
      check(aux3_out, aux_input_three_in);
    end
    {pol_home_in, pol_index_in, pol_alarm_in, alarm_en_in, pol_limit_in} = 10'h3FF;
    {home_sensor_in, index_stop_in, servo_alarm_in, aux_input_three_in} = 8'h00;
    {hard_limit_pos_in, hard_limit_neg_in} = 4'h0;
    cyc(5);
    for (int g = 0; g < 5; g++) begin
      set_grp(5'h01 << g);
      cyc(2);
      grp_drive(g, 1'h1);
      grp_drive((g + 1) % 5, 1'h1);
      cyc(5);
      check(grp_seen(g), 0);
      check(grp_seen((g + 1) % 5), 1);
      grp_drive(g, 1'h0);
      grp_drive((g + 1) % 5, 1'h0);
      cyc(30);
      check(grp_seen(g), 0);
      grp_drive(g, 1'h1);
      cyc(10);
      check(grp_seen(g), 0);
      cyc(30);
      check(grp_seen(g), 1);
      grp_drive(g, 1'h0);
      cyc(40);
    end
    filt_code_in = 3'h7;
    set_grp(5'h01);
    home_sensor_in = 2'h1;
    cyc(60);
    check(home_act_out[0], 0);
    home_sensor_in = 2'h0;
    alarm_en_in = 2'h0;
    set_grp(5'h00);
    cyc(5);
    for (int m = 0; m < 6; m++) begin
      pls_mode_in[2:0] = 3'(m);
      smp(1'h0, 1'h0, s00);
      smp(1'h0, 1'h1, s01);
      smp(1'h1, 1'h0, s10);
      smp(1'h1, 1'h1, s11);
      if (m < 2) begin
        check(s00 | s01, 0);
        check(s10 ^ s11, 3);
        check(s10[0] ^ s10[1], 1);
      end else begin
        check(s10[1] ^ s00[1], 1);
        check(s01[0] ^ s00[0], 1);
        check(s01[1] ^ s00[1], 0);
      end
    end
    pls_mode_in = 6'h00;
    pls_req_in = 2'h3;
    dir_req_in = 2'h3;
    cyc(4);
    emergency_stop_in = 1'h1;
    cyc(5);
    check({cw_out, ccw_out, emg_error_out}, 1);
    emergency_stop_in = 1'h0;
    cyc(5);
    check(emg_error_out, 1);
    err_clr_in = 1'h1;
    cyc(1);
    err_clr_in = 1'h0;
    cyc(3);
    check({cw_out ^ ccw_out, emg_error_out}, 6);
    alarm_en_in = 2'h1;
    servo_alarm_in = 2'h3;
    cyc(5);
    check({cw_out[0], ccw_out[0], cw_out[1] ^ ccw_out[1]}, 1);
    {pls_req_in, alarm_en_in, servo_alarm_in} = 6'h00;
    comp_neg_in[31:0] = 32'h5;
    comp_pos_in[31:0] = 32'hA;
    cyc(4);
    ev_en_in = 14'h007F;
    cyc(2);
    foreach (ev_tab[i]) begin
      exp_q.push_back(14'(ev_tab[i][3]));
      pos_cnt_in[31:0] = 32'(ev_tab[i][0]);
      const_speed_in[0] = ev_tab[i][1][0];
      driving_in[0] = ev_tab[i][2][0];
      cyc(4);
    end
    check(irq_out, 1);
    exp_q.push_back(14'h0000);
    ev_clr_in = 14'h3FFF;
    cyc(3);
    ev_clr_in = 14'h0000;
    cyc(2);
    check(irq_out, 0);
    ev_en_in = 14'h0040;
    pos_cnt_in[31:0] = 32'hC;
    driving_in[0] = 1'h1;
    cyc(4);
    exp_q.push_back(14'h0040);
    driving_in[0] = 1'h0;
    cyc(4);
    check(irq_out, 1);
    foreach (enc_tab[i]) begin
      step_dir = enc_tab[i][0][0];
      enc_updown_in[1] = enc_tab[i][1][0];
      enc_div_in[3:2] = enc_tab[i][2][1:0];
      cyc(6);
      n_up = 0;
      n_dn = 0;
      repeat (16) begin
        step = 1'h1;
        cyc(1);
        step = 1'h0;
        rnd = lfsr(rnd);
        cyc(6 + rnd[2:0]);
      end
      cyc(6);
      check(step_dir ? n_up : n_dn, enc_tab[i][3]);
      check(step_dir ? n_dn : n_up, 0);
      check({mpg_pos_out, mpg_neg_out}, {enc_a, 1'h0, enc_b, 1'h0});
    end
    conclude();
  end
endmodule : test_axis_input_conditioning_events

/* File: src/aice_filter.sv */
// Digital noise filter for one input bit with bypass path.
// Assumes a shared filter tick enable from the top.
`timescale 1ns/1ps
module aice_filter (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Control
  input wire logic tick_in,
  input wire logic filt_en_in,
  // Data
  input wire logic raw_in,
  output logic clean_out
);
  import aice_pkg::*;

  logic sync1_ff;
  logic sync2_ff;
  logic stable_ff;
  logic [2:0] cnt_ff;
  logic out_ff;

  // ****************************************************************
  // Two-flop synchroniser
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  // ****************************************************************
  // Eight ticks of steady level accepted; seven or fewer rejected
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stable_ff <= 1'b0;
      cnt_ff <= 3'h0;
    end else if (sync2_ff != stable_ff) begin
      stable_ff <= sync2_ff;
      cnt_ff <= 3'h0;
    end else if (tick_in && cnt_ff != 3'h7) begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      out_ff <= 1'b0;
    end else if (!filt_en_in) begin
      out_ff <= sync2_ff;
    end else if (tick_in && cnt_ff == 3'h7 && sync2_ff == stable_ff) begin
      out_ff <= stable_ff;
    end
  end

  assign clean_out = out_ff;

  property p_bypass;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (!filt_en_in && $past(!filt_en_in)) |-> (out_ff == $past(sync2_ff));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass path wrong");

endmodule : aice_filter

/* File: src/aice_pkg.sv */
// Constants and types for the per-axis input conditioning and event block.
// Assumes a single 50 MHz clock and plain configuration ports, no bus.
package aice_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int FILT_BASE_NS = 2000;
  localparam int FILT_BASE_CYC = (FILT_BASE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int FILT_CODE_W = 3;
  localparam int FILT_MAX_SHIFT = 13;
  localparam int FILT_TICK_W = 20;

  // ****************************************************************
  // Field layouts
  // ****************************************************************
  localparam int NUM_EVENTS = 7;
  localparam int EV_GE_NEG = 0;
  localparam int EV_LT_NEG = 1;
  localparam int EV_GE_POS = 2;
  localparam int EV_LT_POS = 3;
  localparam int EV_CS_END = 4;
  localparam int EV_CS_START = 5;
  localparam int EV_DRV_DONE = 6;
  localparam int NUM_FILT_GRP = 5;
  localparam int POS_W = 32;
  localparam int PLS_MODE_W = 3;
  localparam logic [PLS_MODE_W-1:0] PLS_MODE_LAST_DUAL = 3'h1;

  // Reset values
  localparam logic [6:0] EV_FLAGS_RST = 7'h00;

  typedef enum logic [1:0] {
    AICE_ENC_QUAD,
    AICE_ENC_UPDN
  } aice_enc_mode_e;

  typedef enum logic [1:0] {
    AICE_DIV_1,
    AICE_DIV_2,
    AICE_DIV_4
  } aice_enc_div_e;

endpackage : aice_pkg

/* File: src/aice_top.sv */
// Per-axis input conditioning, polarity, encoder/pulse mode and events.
// Assumes one 50 MHz clock; configuration and status are plain ports.
`timescale 1ns/1ps
module aice_top #(
  parameter int NUM_AXES = 2,
  parameter int BASE_CYC = aice_pkg::FILT_BASE_CYC
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Filter configuration
  input wire logic [aice_pkg::FILT_CODE_W-1:0] filt_code_in,
  input wire logic filter_en_limits_group_in,
  input wire logic filter_en_index_group_in,
  input wire logic filter_en_servo_group_in,
  input wire logic filter_en_manual_pulse_group_in,
  input wire logic filter_en_aux_input_group_in,
  // Common sensor
  input wire logic emergency_stop_in,
  // Per-axis sensors
  input wire logic [NUM_AXES-1:0] hard_limit_pos_in,
  input wire logic [NUM_AXES-1:0] hard_limit_neg_in,
  input wire logic [NUM_AXES-1:0] home_sensor_in,
  input wire logic [NUM_AXES-1:0] near_home_sensor_in,
  input wire logic [NUM_AXES-1:0] index_stop_in,
  input wire logic [NUM_AXES-1:0] servo_alarm_in,
  input wire logic [NUM_AXES-1:0] in_position_in,
  input wire logic [NUM_AXES-1:0] manual_pulse_pos_in,
  input wire logic [NUM_AXES-1:0] manual_pulse_neg_in,
  input wire logic [NUM_AXES-1:0] aux_input_three_in,
  // Polarity and enables, one bit per axis, 1 = active high
  input wire logic [NUM_AXES-1:0] pol_limit_in,
  input wire logic [NUM_AXES-1:0] pol_home_in,
  input wire logic [NUM_AXES-1:0] pol_near_home_in,
  input wire logic [NUM_AXES-1:0] pol_index_in,
  input wire logic [NUM_AXES-1:0] alarm_en_in,
  input wire logic [NUM_AXES-1:0] pol_alarm_in,
  input wire logic [NUM_AXES-1:0] inpos_en_in,
  input wire logic [NUM_AXES-1:0] pol_inpos_in,
  // Encoder and pulse configuration
  input wire logic [NUM_AXES-1:0] enc_updown_in,
  input wire logic [2*NUM_AXES-1:0] enc_div_in,
  input wire logic [aice_pkg::PLS_MODE_W*NUM_AXES-1:0] pls_mode_in,
  // Motion core signals
  input wire logic [NUM_AXES-1:0] pls_req_in,
  input wire logic [NUM_AXES-1:0] dir_req_in,
  input wire logic [aice_pkg::POS_W*NUM_AXES-1:0] pos_cnt_in,
  input wire logic [aice_pkg::POS_W*NUM_AXES-1:0] comp_neg_in,
  input wire logic [aice_pkg::POS_W*NUM_AXES-1:0] comp_pos_in,
  input wire logic [NUM_AXES-1:0] const_speed_in,
  input wire logic [NUM_AXES-1:0] driving_in,
  // Events
  input wire logic [aice_pkg::NUM_EVENTS*NUM_AXES-1:0] ev_en_in,
  input wire logic [aice_pkg::NUM_EVENTS*NUM_AXES-1:0] ev_clr_in,
  input wire logic err_clr_in,
  // Outputs
  output logic [aice_pkg::NUM_EVENTS*NUM_AXES-1:0] ev_flags_out,
  output logic irq_out,
  output logic emg_error_out,
  output logic [NUM_AXES-1:0] cw_out,
  output logic [NUM_AXES-1:0] ccw_out,
  output logic [NUM_AXES-1:0] enc_up_out,
  output logic [NUM_AXES-1:0] enc_dn_out,
  output logic [NUM_AXES-1:0] limit_pos_act_out,
  output logic [NUM_AXES-1:0] limit_neg_act_out,
  output logic [NUM_AXES-1:0] home_act_out,
  output logic [NUM_AXES-1:0] near_home_act_out,
  output logic [NUM_AXES-1:0] index_act_out,
  output logic [NUM_AXES-1:0] alarm_act_out,
  output logic [NUM_AXES-1:0] inpos_act_out,
  output logic [NUM_AXES-1:0] mpg_pos_out,
  output logic [NUM_AXES-1:0] mpg_neg_out,
  output logic [NUM_AXES-1:0] aux3_out
);
  import aice_pkg::*;

  localparam int NE = NUM_EVENTS;

  // ****************************************************************
  // Filter tick: base period shifted by code
  // ****************************************************************
  logic [FILT_TICK_W-1:0] tick_cnt_ff;
  logic tick_ff;
  logic [FILT_TICK_W-1:0] tick_lim;

  always_comb begin
    tick_lim = (FILT_TICK_W'(BASE_CYC) << ((filt_code_in == 3'h0) ? 0 :
      (int'(filt_code_in) + 6))) >> 3;
    tick_lim = tick_lim - FILT_TICK_W'(1);
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff >= tick_lim) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + FILT_TICK_W'(1);
      tick_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Filters
  // ****************************************************************
  logic emg_f;

  aice_filter u_emg (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .tick_in(tick_ff),
    .filt_en_in(filter_en_limits_group_in),
    .raw_in(emergency_stop_in),
    .clean_out(emg_f)
  );

  logic [NUM_AXES-1:0] lp_f, ln_f, hm_f, nh_f, ix_f, al_f, ip_f, mp_f, mn_f, a3_f;
  logic [NUM_AXES-1:0] halt;

  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++) begin : g_axis
      logic [9:0] raw;
      logic [9:0] en;
      logic [9:0] cln;
      logic [POS_W-1:0] pos;
      logic [NE-1:0] cond;
      logic cs_ff;
      logic drv_ff;
      logic [NE-1:0] cond_ff;
      logic [NE-1:0] ev;
      logic [1:0] qa_ff;
      logic [1:0] div_cnt_ff;
      logic [PLS_MODE_W-1:0] mode;

      assign raw = {aux_input_three_in[g], manual_pulse_neg_in[g], manual_pulse_pos_in[g],
        in_position_in[g], servo_alarm_in[g], index_stop_in[g], near_home_sensor_in[g],
        home_sensor_in[g], hard_limit_neg_in[g], hard_limit_pos_in[g]};
      assign en = {filter_en_aux_input_group_in,
        {2{filter_en_manual_pulse_group_in}},
        {2{filter_en_servo_group_in}},
        filter_en_index_group_in,
        {4{filter_en_limits_group_in}}};

      for (genvar b = 0; b < 10; b++) begin : g_bit
        aice_filter u_f (
          .ref_clk_in(ref_clk_in),
          .rst_b_in(rst_b_in),
          .tick_in(tick_ff),
          .filt_en_in(en[b]),
          .raw_in(raw[b]),
          .clean_out(cln[b])
        );
      end

      assign {a3_f[g], mn_f[g], mp_f[g], ip_f[g], al_f[g], ix_f[g], nh_f[g], hm_f[g],
        ln_f[g], lp_f[g]} = cln;

      // Polarity and enables
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          limit_pos_act_out[g] <= 1'b0;
          limit_neg_act_out[g] <= 1'b0;
          home_act_out[g] <= 1'b0;
          near_home_act_out[g] <= 1'b0;
          index_act_out[g] <= 1'b0;
          alarm_act_out[g] <= 1'b0;
          inpos_act_out[g] <= 1'b0;
          mpg_pos_out[g] <= 1'b0;
          mpg_neg_out[g] <= 1'b0;
          aux3_out[g] <= 1'b0;
        end else begin
          limit_pos_act_out[g] <= ~(lp_f[g] ^ pol_limit_in[g]);
          limit_neg_act_out[g] <= ~(ln_f[g] ^ pol_limit_in[g]);
          home_act_out[g] <= ~(hm_f[g] ^ pol_home_in[g]);
          near_home_act_out[g] <= ~(nh_f[g] ^ pol_near_home_in[g]);
          index_act_out[g] <= ~(ix_f[g] ^ pol_index_in[g]);
          alarm_act_out[g] <= alarm_en_in[g] & ~(al_f[g] ^ pol_alarm_in[g]);
          inpos_act_out[g] <= inpos_en_in[g] & ~(ip_f[g] ^ pol_inpos_in[g]);
          mpg_pos_out[g] <= mp_f[g];
          mpg_neg_out[g] <= mn_f[g];
          aux3_out[g] <= a3_f[g];
        end
      end

      // Pulse output
      assign halt[g] = emg_error_out | alarm_act_out[g];
      assign mode = pls_mode_in[PLS_MODE_W*g +: PLS_MODE_W];
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          cw_out[g] <= 1'b0;
          ccw_out[g] <= 1'b0;
        end else if (halt[g]) begin
          cw_out[g] <= 1'b0;
          ccw_out[g] <= 1'b0;
        end else if (mode <= PLS_MODE_LAST_DUAL) begin
          cw_out[g] <= pls_req_in[g] & ~dir_req_in[g];
          ccw_out[g] <= pls_req_in[g] & dir_req_in[g];
        end else begin
          cw_out[g] <= pls_req_in[g];
          ccw_out[g] <= dir_req_in[g];
        end
      end

      // Encoder: quadrature with division, or up/down pulses
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          qa_ff <= 2'h0;
          div_cnt_ff <= 2'h0;
          enc_up_out[g] <= 1'b0;
          enc_dn_out[g] <= 1'b0;
        end else begin
          qa_ff <= {mp_f[g], mn_f[g]};
          enc_up_out[g] <= 1'b0;
          enc_dn_out[g] <= 1'b0;
          if (enc_updown_in[g]) begin
            enc_up_out[g] <= mp_f[g] & ~qa_ff[1];
            enc_dn_out[g] <= mn_f[g] & ~qa_ff[0];
          end else if (qa_ff != {mp_f[g], mn_f[g]}) begin
            div_cnt_ff <= div_cnt_ff + 2'h1;
            if (enc_div_in[2*g +: 2] == 2'(AICE_DIV_1) ||
                (enc_div_in[2*g +: 2] == 2'(AICE_DIV_2) && div_cnt_ff[0]) ||
                div_cnt_ff == 2'h3) begin
              enc_up_out[g] <= (qa_ff[1] ^ mn_f[g]);
              enc_dn_out[g] <= ~(qa_ff[1] ^ mn_f[g]);
            end
          end
        end
      end

      // Events
      assign pos = pos_cnt_in[POS_W*g +: POS_W];
      always_comb begin
        cond = '0;
        cond[EV_GE_NEG] = $signed(pos) >= $signed(comp_neg_in[POS_W*g +: POS_W]);
        cond[EV_LT_NEG] = $signed(pos) < $signed(comp_neg_in[POS_W*g +: POS_W]);
        cond[EV_GE_POS] = $signed(pos) >= $signed(comp_pos_in[POS_W*g +: POS_W]);
        cond[EV_LT_POS] = $signed(pos) < $signed(comp_pos_in[POS_W*g +: POS_W]);
      end
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          cs_ff <= 1'b0;
          drv_ff <= 1'b0;
          cond_ff <= '0;
        end else begin
          cs_ff <= const_speed_in[g];
          drv_ff <= driving_in[g];
          cond_ff <= cond;
        end
      end
      always_comb begin
        ev = '0;
        ev[3:0] = cond[3:0] & ~cond_ff[3:0];
        ev[EV_CS_END] = cs_ff & ~const_speed_in[g];
        ev[EV_CS_START] = ~cs_ff & const_speed_in[g];
        ev[EV_DRV_DONE] = drv_ff & ~driving_in[g];
      end
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          ev_flags_out[NE*g +: NE] <= EV_FLAGS_RST;
        end else begin
          ev_flags_out[NE*g +: NE] <= (ev_flags_out[NE*g +: NE] & ~ev_clr_in[NE*g +: NE])
            | (ev & ev_en_in[NE*g +: NE]);
        end
      end

      property p_cs_start;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
          (!cs_ff && const_speed_in[g] && ev_en_in[NE*g+EV_CS_START])
            |=> ev_flags_out[NE*g+EV_CS_START];
      endproperty
      a_cs_start: assert property (p_cs_start) else $error("start flag missed");
      property p_drv_done;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
          $fell(driving_in[g]) && ev_en_in[NE*g+EV_DRV_DONE]
            |=> ev_flags_out[NE*g+EV_DRV_DONE];
      endproperty
      a_drv_done: assert property (p_drv_done) else $error("done flag missed");
      property p_halt;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
          halt[g] |=> (!cw_out[g] && !ccw_out[g]);
      endproperty
      a_halt: assert property (p_halt) else $error("pulse during halt");
      property p_set_wins;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
          (ev[EV_CS_END] && ev_en_in[NE*g+EV_CS_END]) |=> ev_flags_out[NE*g+EV_CS_END];
      endproperty
      a_set_wins: assert property (p_set_wins) else $error("end flag lost");
      property p_alarm_dis;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
          !alarm_en_in[g] |=> !alarm_act_out[g];
      endproperty
      a_alarm_dis: assert property (p_alarm_dis) else $error("alarm not masked");
      property p_dual;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
          (!halt[g] && mode <= PLS_MODE_LAST_DUAL) |=> !(cw_out[g] && ccw_out[g]);
      endproperty
      a_dual: assert property (p_dual) else $error("both channels pulsed");
    end
  endgenerate

  // ****************************************************************
  // Emergency error flag and interrupt
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      emg_error_out <= 1'b0;
    end else if (emg_f) begin
      emg_error_out <= 1'b1;
    end else if (err_clr_in) begin
      emg_error_out <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |ev_flags_out;
    end
  end

  sequence s_emg_halt;
    emg_error_out ##1 (cw_out == '0 && ccw_out == '0);
  endsequence
  property p_emg;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      emg_f |=> s_emg_halt;
  endproperty
  a_emg: assert property (p_emg) else $error("emergency not handled");
  property p_irq;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (|ev_flags_out) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

endmodule : aice_top
